// ---- hw/frs_map.svh ----
// register offsets, field positions and reset values for the rate and status register bank
`ifndef FRS_MAP_SVH
`define FRS_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses on the host port)
// ----------------------------------------------------------------
`define FRS_ADDR_W 10
`define FRS_OFF_STATUS 10'h3f4
`define FRS_OFF_FIFO 10'h3f5
`define FRS_OFF_INPUT 10'h3f7

// ----------------------------------------------------------------
// rate and precompensation select fields
// ----------------------------------------------------------------
`define FRS_DSR_RESET 8'h02
`define FRS_BIT_LOWPWR 6
`define FRS_BIT_SRST 7
`define FRS_BIT_NO_WRITE_SHIFT 2
`define FRS_PC_LSB 2
`define FRS_PC_MSB 4
`define FRS_PC_DEFAULT 3'h0
`define FRS_PC_OFF 3'h7
`define FRS_RATE_1M 2'h3
`define FRS_RATE_500K 2'h0
`define FRS_RATE_300K 2'h1
`define FRS_RATE_250K 2'h2

// ----------------------------------------------------------------
// write shift in 41.67 ns steps
// ----------------------------------------------------------------
`define FRS_SHIFT_NONE 3'h0
`define FRS_SHIFT_DEF_1M 3'h1
`define FRS_SHIFT_DEF_LOW 3'h3

// ----------------------------------------------------------------
// read values
// ----------------------------------------------------------------
`define FRS_OE_ALL 8'hff
`define FRS_OE_BASIC 8'h80
`define FRS_OE_NONE 8'h00
`define FRS_READ_IDLE 8'h00
`define FRS_TRACK_RESET 8'h00

`endif

// ---- hw/frs_pkg.sv ----
// types shared by the rate and status register bank
package frs_pkg;

   // compatibility layout of the input register
   typedef enum logic [1:0] {
      FRS_LAYOUT_BASIC = 2'h0,
      FRS_LAYOUT_SECOND = 2'h1,
      FRS_LAYOUT_THIRD = 2'h2
   } frs_layout_t;

   // complete state of the register bank
   typedef struct packed {
      logic [7:0] rdata;    // read data, valid one cycle after the strobe
      logic [7:0] rd_oe;    // per-bit drive of the read data
      logic [1:0] rate;     // active rate select
      logic [2:0] precomp;  // precompensation code
      logic lowpwr;         // manual low power
      logic no_write_shift;         // no-precompensation flag from the config write
      logic srst;           // self-clearing soft reset pulse
      logic fifo_en;        // fifo enabled by configuration
      logic fifo_act;       // fifo buffering live in this command
      logic fifo_clr;       // clear pulse at execution entry
      logic push;           // host byte toward the core
      logic [7:0] wbyte;    // byte written by the host
      logic pop;            // host took a byte from the core
      logic term;           // overrun or underrun termination pulse
      logic [7:0] track;    // precompensation start track
      logic [2:0] shift;    // applied write shift
      logic chg_s1;         // media change synchroniser, first stage
      logic chg_s2;         // media change synchroniser, second stage
   } frs_state_t;

endpackage

// ---- hw/frs_regs.sv ----
// rate select, main status, data register and input register logic
`timescale 1ns/10ps
`default_nettype none
`include "frs_map.svh"

module frs_regs (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // host register port
   input wire logic [`FRS_ADDR_W-1:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   output logic [7:0] rdata_oe_o,
   // command engine status
   input wire logic [3:0] seek_busy_i,
   input wire logic cmd_busy_i,
   input wire logic exec_phase_i,
   input wire logic polled_mode_i,
   input wire logic to_host_i,
   input wire logic req_ready_i,
   input wire logic [7:0] core_byte_i,
   // command engine events
   input wire logic cmd_start_i,
   input wire logic exec_entry_i,
   input wire logic cfg_load_i,
   input wire logic cfg_fifo_en_i,
   input wire logic [7:0] cfg_track_i,
   input wire logic overrun_i,
   // neighbouring control
   input wire logic out_reg_rst_i,
   input wire logic dma_gate_enable_i,
   input wire logic [1:0] layout_i,
   // drive cable
   input wire logic media_changed_i,
   // data path toward the core
   output logic fifo_push_o,
   output logic [7:0] fifo_wdata_o,
   output logic fifo_pop_o,
   output logic fifo_clear_o,
   output logic fifo_active_o,
   output logic fifo_enable_o,
   output logic terminate_o,
   // controller control
   output logic soft_rst_o,
   output logic clk_stop_o,
   output logic [1:0] rate_o,
   output logic [2:0] write_shift_o,
   output logic no_write_shift_o,
   output logic [7:0] precomp_track_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   frs_pkg::frs_state_t q; // registered state
   frs_pkg::frs_state_t n; // next state
   logic [7:0] status; // live main status byte
   logic wake; // status or data register access

   // ----------------------------------------------------------------
   // main status and next state
   // ----------------------------------------------------------------
   // status is built from live inputs so a read just after a transfer is current
   always_comb
   begin
      status = {req_ready_i,
         to_host_i,
         polled_mode_i & exec_phase_i,
         cmd_busy_i,
         seek_busy_i};
      wake = (wr_i | rd_i) & ((addr_i == `FRS_OFF_STATUS) | (addr_i == `FRS_OFF_FIFO));
      n = q;
      n.rdata = `FRS_READ_IDLE;
      n.rd_oe = `FRS_OE_NONE;
      n.srst = 1'b0;
      n.push = 1'b0;
      n.pop = 1'b0;
      n.fifo_clr = 1'b0;
      n.term = 1'b0;
      // media change pin crosses in through two stages
      n.chg_s1 = media_changed_i;
      n.chg_s2 = q.chg_s1;
      // any status or data access ends manual low power
      // cleared before the write decode, so a select write with bit six sets it again
      if (wake)
      begin
         n.lowpwr = 1'b0;
      end
      // host writes
      if (wr_i)
      begin
         unique case (addr_i)
            `FRS_OFF_STATUS:
            begin
               // a write here lands in the rate select, never in status
               n.rate = wdata_i[1:0];
               n.precomp = wdata_i[`FRS_PC_MSB:`FRS_PC_LSB];
               // bit five is ignored, software keeps it zero
               n.lowpwr = wdata_i[`FRS_BIT_LOWPWR];
               n.srst = wdata_i[`FRS_BIT_SRST];
            end
            `FRS_OFF_FIFO:
            begin
               // only accepted while the core asks for a host write
               if (req_ready_i && !to_host_i)
               begin
                  n.push = 1'b1;
                  n.wbyte = wdata_i;
               end
            end
            `FRS_OFF_INPUT:
            begin
               // config write shares the rate with the select register
               n.rate = wdata_i[1:0];
               n.no_write_shift = wdata_i[`FRS_BIT_NO_WRITE_SHIFT];
            end
            default:
            begin
               // unmapped writes are dropped
            end
         endcase
      end
      // host reads
      if (rd_i)
      begin
         unique case (addr_i)
            `FRS_OFF_STATUS:
            begin
               n.rdata = status;
               n.rd_oe = `FRS_OE_ALL;
            end
            `FRS_OFF_FIFO:
            begin
               n.rdata = core_byte_i;
               n.rd_oe = `FRS_OE_ALL;
               n.pop = req_ready_i & to_host_i;
            end
            `FRS_OFF_INPUT:
            begin
               unique case (layout_i)
                  frs_pkg::FRS_LAYOUT_SECOND:
                  begin
                     // density bit low for the two fast rates
                     n.rdata = {~q.chg_s2, 4'hf, q.rate,
                        ~((q.rate == `FRS_RATE_500K) | (q.rate == `FRS_RATE_1M))};
                     n.rd_oe = `FRS_OE_ALL;
                  end
                  frs_pkg::FRS_LAYOUT_THIRD:
                  begin
                     n.rdata = {~q.chg_s2, 3'h0, dma_gate_enable_i, q.no_write_shift, q.rate};
                     n.rd_oe = `FRS_OE_ALL;
                  end
                  default:
                  begin
                     // basic layout: lower lines float, a hazard for tools reading them
                     n.rdata = {~q.chg_s2, 7'h00};
                     n.rd_oe = `FRS_OE_BASIC;
                  end
               endcase
            end
            default:
            begin
               // unmapped reads answer zero with the bus undriven
            end
         endcase
      end
      // configuration command
      if (cfg_load_i)
      begin
         n.fifo_en = cfg_fifo_en_i;
         n.track = cfg_track_i;
      end
      // parameters are always paced byte by byte
      if (cmd_start_i)
      begin
         n.fifo_act = 1'b0;
      end
      // execution entry flushes stale data
      if (exec_entry_i)
      begin
         n.fifo_clr = 1'b1;
         n.fifo_act = q.fifo_en;
      end
      // overrun ends command; zero fill and drain belong to the core
      if (overrun_i)
      begin
         n.term = 1'b1;
         n.fifo_act = 1'b0;
      end
      // soft reset keeps rate and precompensation, drops fifo and low power
      if (q.srst || out_reg_rst_i)
      begin
         n.lowpwr = 1'b0;
         n.fifo_en = 1'b0;
         n.fifo_act = 1'b0;
      end
      // write shift from the stored code
      if (q.precomp == `FRS_PC_OFF)
      begin
         n.shift = `FRS_SHIFT_NONE;
      end
      else if (q.precomp == `FRS_PC_DEFAULT)
      begin
         n.shift = (q.rate == `FRS_RATE_1M) ? `FRS_SHIFT_DEF_1M : `FRS_SHIFT_DEF_LOW;
      end
      else
      begin
         n.shift = q.precomp;
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   // hard reset loads the select value 02h and a clear fifo setup
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
      begin
         q <= '0;
         // select value 02h: default precomp code over the 250k rate
         q.rate <= `FRS_RATE_250K;
         q.precomp <= `FRS_PC_DEFAULT;
         q.shift <= `FRS_SHIFT_DEF_LOW;
         q.track <= `FRS_TRACK_RESET;
      end
      else
      begin
         q <= n;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign rdata_o = q.rdata;
   assign rdata_oe_o = q.rd_oe;
   assign fifo_push_o = q.push;
   assign fifo_wdata_o = q.wbyte;
   assign fifo_pop_o = q.pop;
   assign fifo_clear_o = q.fifo_clr;
   assign fifo_active_o = q.fifo_act;
   assign fifo_enable_o = q.fifo_en;
   assign terminate_o = q.term;
   assign soft_rst_o = q.srst;
   assign clk_stop_o = q.lowpwr;
   assign rate_o = q.rate;
   assign write_shift_o = q.shift;
   assign no_write_shift_o = q.no_write_shift;
   assign precomp_track_o = q.track;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (sys_rst_i);

   // select write with reset bit, then pulse ends by itself
   sequence srst_write_s;
      wr_i && addr_i == `FRS_OFF_STATUS && wdata_i[`FRS_BIT_SRST];
   endsequence
   sequence srst_pulse_s;
      soft_rst_o ##1 !soft_rst_o;
   endsequence

   shift_code_off_a: assert property (q.precomp == `FRS_PC_OFF |=> write_shift_o == 3'h0)
      else $error("disabled code gave a write shift");
   shift_def_fast_a: assert property (q.precomp == 3'h0 && q.rate == 2'h3
      |=> write_shift_o == 3'h1)
      else $error("default shift wrong at fast rate");
   shift_def_slow_a: assert property (q.precomp == 3'h0 && q.rate != 2'h3
      |=> write_shift_o == 3'h3)
      else $error("default shift wrong at slow rate");
   lowpwr_enter_a: assert property (wr_i && addr_i == `FRS_OFF_STATUS
      && wdata_i[`FRS_BIT_LOWPWR] && !soft_rst_o && !out_reg_rst_i |=> clk_stop_o)
      else $error("low power not entered");
   lowpwr_wake_a: assert property (rd_i && (addr_i == `FRS_OFF_STATUS
      || addr_i == `FRS_OFF_FIFO) |=> !clk_stop_o)
      else $error("access did not wake");
   srst_self_clr_a: assert property (srst_write_s |=> srst_pulse_s)
      else $error("soft reset not a single pulse");
   rate_kept_srst_a: assert property (soft_rst_o && !wr_i |=> $stable(rate_o))
      else $error("soft reset changed the rate");
   status_read_a: assert property (rd_i && addr_i == `FRS_OFF_STATUS
      |=> rdata_o == $past(status) && rdata_oe_o == 8'hff)
      else $error("status read wrong");
   fifo_off_srst_a: assert property (soft_rst_o && !cfg_load_i
      |=> !fifo_enable_o && !fifo_active_o)
      else $error("fifo survived soft reset");
   exec_clear_a: assert property (exec_entry_i |=> fifo_clear_o ##1 !fifo_clear_o)
      else $error("exec entry did not clear fifo once");
   overrun_end_a: assert property (overrun_i |=> terminate_o)
      else $error("overrun did not terminate");
   basic_float_a: assert property (rd_i && addr_i == `FRS_OFF_INPUT && layout_i == 2'h0
      |=> rdata_oe_o == 8'h80 && rdata_o[7] == !$past(q.chg_s2))
      else $error("basic input layout wrong");
   second_ones_a: assert property (rd_i && addr_i == `FRS_OFF_INPUT && layout_i == 2'h1
      |=> rdata_o[6:3] == 4'hf && rdata_o[2:1] == $past(rate_o))
      else $error("second input layout wrong");

   // data path, input layout and configuration checks
   push_gate_a: assert property (wr_i && addr_i == `FRS_OFF_FIFO
      |=> fifo_push_o == ($past(req_ready_i) && !$past(to_host_i)))
      else $error("data write push not gated by request");
   third_layout_a: assert property (rd_i && addr_i == `FRS_OFF_INPUT && layout_i == 2'h2
      |=> rdata_o[6:4] == 3'h0 && rdata_o[2] == $past(no_write_shift_o)
      && rdata_o[1:0] == $past(rate_o))
      else $error("third input layout wrong");
   cmd_start_off_a: assert property (cmd_start_i && !exec_entry_i |=> !fifo_active_o)
      else $error("fifo live at command start");
   cfg_load_a: assert property (cfg_load_i && !soft_rst_o && !out_reg_rst_i
      |=> fifo_enable_o == $past(cfg_fifo_en_i) && precomp_track_o == $past(cfg_track_i))
      else $error("configuration not loaded");

endmodule

`default_nettype wire

// ---- tb/frs_core_model.sv ----
// behavioural model of the command engine that sits behind the register bank
`timescale 1ns/10ps
`default_nettype none
module frs_core_model (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic sys_rst_i,
   // phase set by the bench: 0 idle, 1 command, 2 execution, 3 result
   input wire logic [1:0] phase_i,
   // status levels and events toward the bank
   output logic cmd_busy_o,
   output logic exec_o,
   output logic to_host_o,
   output logic req_o,
   output logic cmd_start_o,
   output logic exec_entry_o,
   output logic [7:0] byte_o
);
   logic [1:0] phase_q; // phase of the last cycle, for entry pulses
   // ----------------------------------------------------------------
   // phase history
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         phase_q <= 2'h0;
      else
         phase_q <= phase_i;
   end
   // levels follow the phase; entry pulses last one cycle
   always_comb
   begin
      cmd_busy_o = phase_i != 2'h0;
      exec_o = phase_i == 2'h2;
      to_host_o = phase_i[1];
      req_o = 1'b1;
      cmd_start_o = (phase_i == 2'h1) && (phase_q != 2'h1);
      exec_entry_o = (phase_i == 2'h2) && (phase_q != 2'h2);
      // no byte offered while writing: show the inverse pattern
      byte_o = to_host_o ? 8'ha5 : 8'h5a;
   end
endmodule
`default_nettype wire

// ---- tb/floppy_rate_status_fifo_regs_tb.sv ----
// self-checking bench for the rate, status and data register bank
`timescale 1ns/10ps
`default_nettype none
`include "frs_map.svh"
module floppy_rate_status_fifo_regs_tb;
   // ----------------------------------------------------------------
   // stimulus and observed signals
   // ----------------------------------------------------------------
   logic clk_sys_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [`FRS_ADDR_W-1:0] addr = '0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [3:0] seek = 4'h0;
   logic polled = 1'b0;
   logic cfg_load = 1'b0;
   logic cfg_en = 1'b0;
   logic [7:0] cfg_track = 8'h00;
   logic overrun = 1'b0;
   logic dma = 1'b0;
   logic [1:0] layout = 2'h1;
   logic chg = 1'b0; // cable level, high means media changed
   logic orst = 1'b0; // soft reset from the output register
   logic [1:0] phase = 2'h0;
   logic [7:0] rdata, oe, wbyte, track, cbyte, d, e;
   logic push, pop, clr, act, fen, term, srst, cstop, nows;
   logic busy, exe, dir, req, cst, ent;
   logic [1:0] rate;
   logic [2:0] shift;
   int num_errors = 0;
   int comparisons = 0;
   int cycles = 0;
   // 100 MHz clock
   always #5 clk_sys_i = ~clk_sys_i;
   // ----------------------------------------------------------------
   // design and partner
   // ----------------------------------------------------------------
   frs_regs dut_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .addr_i(addr),
      .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .rdata_oe_o(oe),
      .seek_busy_i(seek), .cmd_busy_i(busy), .exec_phase_i(exe),
      .polled_mode_i(polled), .to_host_i(dir), .req_ready_i(req),
      .core_byte_i(cbyte), .cmd_start_i(cst), .exec_entry_i(ent),
      .cfg_load_i(cfg_load), .cfg_fifo_en_i(cfg_en), .cfg_track_i(cfg_track),
      .overrun_i(overrun), .out_reg_rst_i(orst), .dma_gate_enable_i(dma),
      .layout_i(layout), .media_changed_i(chg), .fifo_push_o(push),
      .fifo_wdata_o(wbyte), .fifo_pop_o(pop), .fifo_clear_o(clr),
      .fifo_active_o(act), .fifo_enable_o(fen), .terminate_o(term),
      .soft_rst_o(srst), .clk_stop_o(cstop), .rate_o(rate),
      .write_shift_o(shift), .no_write_shift_o(nows), .precomp_track_o(track));
   frs_core_model core_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
      .phase_i(phase), .cmd_busy_o(busy), .exec_o(exe), .to_host_o(dir),
      .req_o(req), .cmd_start_o(cst), .exec_entry_o(ent), .byte_o(cbyte));
   // ----------------------------------------------------------------
   // access tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // one-cycle write; returns just after the taking edge
   task automatic wr_reg(input logic [9:0] a, input logic [7:0] v);
      @(posedge clk_sys_i);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk_sys_i);
      wr <= 1'b0;
      #1;
   endtask
   // one-cycle read; data stand only in the following cycle
   task automatic rd_reg(input logic [9:0] a);
      @(posedge clk_sys_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1;
      d = rdata;
      e = oe;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask
   task automatic finish_test;
      $display("errors %0d comparisons %0d", num_errors, comparisons);
      if (num_errors == 0 && comparisons > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   // hang guard, far above the length of the sequence
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         num_errors++;
         finish_test();
      end
   end
   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial
   begin
      repeat (16) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      step(1);
      chk(rate, 8'h02);
      chk(shift, 8'h03);
      chk(track, 8'h00);
      chk(fen, 8'h00);
      // every precomp code at the 250k rate, then default at 1M
      for (int c = 0; c < 8; c++)
      begin
         wr_reg(`FRS_OFF_STATUS, {3'h0, c[2:0], 2'h2});
         step(1);
         chk(shift, (c == 0) ? 8'h03 : (c == 7) ? 8'h00 : 8'(c));
      end
      wr_reg(`FRS_OFF_STATUS, 8'h03);
      step(1);
      chk(shift, 8'h01);
      // every rate code, seen at the port and in the second layout
      for (int r = 0; r < 4; r++)
      begin
         wr_reg(`FRS_OFF_STATUS, {6'h00, r[1:0]});
         rd_reg(`FRS_OFF_INPUT);
         chk(rate, 8'(r));
         chk(d, {5'h1f, r[1:0], (r == 1 || r == 2)});
         chk(e, 8'hff);
      end
      // basic layout drives bit 7 only, inverted cable level
      @(posedge clk_sys_i);
      layout <= 2'h0;
      chg <= 1'b1;
      step(3);
      rd_reg(`FRS_OFF_INPUT);
      chk(d, 8'h00);
      chk(e, 8'h80);
      // third layout after a config write that overrides the rate
      @(posedge clk_sys_i);
      layout <= 2'h2;
      dma <= 1'b1;
      chg <= 1'b0;
      wr_reg(`FRS_OFF_INPUT, 8'h05);
      step(2);
      rd_reg(`FRS_OFF_INPUT);
      chk(d, 8'h8d);
      chk(rate, 8'h01);
      chk(nows, 8'h01);
      // idle status, then a command byte and fifo configuration
      @(posedge clk_sys_i);
      seek <= 4'h9;
      polled <= 1'b1;
      rd_reg(`FRS_OFF_STATUS);
      chk(d, 8'h89);
      chk(e, 8'hff);
      @(posedge clk_sys_i);
      phase <= 2'h1;
      wr_reg(`FRS_OFF_FIFO, 8'h46);
      chk(push, 8'h01);
      chk(wbyte, 8'h46);
      chk(act, 8'h00);
      @(posedge clk_sys_i);
      cfg_load <= 1'b1;
      cfg_en <= 1'b1;
      cfg_track <= 8'h05;
      @(posedge clk_sys_i);
      cfg_load <= 1'b0;
      #1;
      chk(fen, 8'h01);
      chk(track, 8'h05);
      // execution entry clears the fifo; status, data and status reads one idle cycle apart
      @(posedge clk_sys_i);
      phase <= 2'h2;
      step(1);
      chk(clr, 8'h01);
      chk(act, 8'h01);
      rd_reg(`FRS_OFF_STATUS);
      chk(d, 8'hf9);
      rd_reg(`FRS_OFF_FIFO);
      chk(d, 8'ha5);
      chk(pop, 8'h01);
      rd_reg(`FRS_OFF_STATUS);
      chk(d, 8'hf9);
      wr_reg(`FRS_OFF_FIFO, 8'h11);
      chk(push, 8'h00);
      // overrun ends the transfer
      @(posedge clk_sys_i);
      overrun <= 1'b1;
      @(posedge clk_sys_i);
      overrun <= 1'b0;
      #1;
      chk(term, 8'h01);
      chk(act, 8'h00);
      // manual low power, woken by a status read
      wr_reg(`FRS_OFF_STATUS, 8'h41);
      chk(cstop, 8'h01);
      rd_reg(`FRS_OFF_STATUS);
      chk(cstop, 8'h00);
      // soft reset pulses once, keeps rate, drops fifo enable
      wr_reg(`FRS_OFF_STATUS, 8'hc5);
      chk(srst, 8'h01);
      chk(rate, 8'h01);
      step(1);
      chk(srst, 8'h00);
      chk(fen, 8'h00);
      chk(shift, 8'h01);
      chk(cstop, 8'h00);
      // output register reset also drops a freshly enabled fifo, rate kept
      @(posedge clk_sys_i);
      cfg_load <= 1'b1;
      cfg_en <= 1'b1;
      @(posedge clk_sys_i);
      cfg_load <= 1'b0;
      orst <= 1'b1;
      #1;
      chk(fen, 8'h01);
      @(posedge clk_sys_i);
      orst <= 1'b0;
      #1;
      chk(fen, 8'h00);
      chk(rate, 8'h01);
      // unmapped read answers nothing
      rd_reg(10'h3f0);
      chk(d, 8'h00);
      chk(e, 8'h00);
      // second hardware reset restores the select register; core idles on the same edge
      @(posedge clk_sys_i);
      sys_rst_i <= 1'b1;
      phase <= 2'h0;
      repeat (2) @(posedge clk_sys_i);
      sys_rst_i <= 1'b0;
      step(1);
      chk(rate, 8'h02);
      chk(shift, 8'h03);
      chk(fen, 8'h00);
      chk(nows, 8'h00);
      finish_test();
   end
endmodule
`default_nettype wire
